// [rtl/adc_serial_pkg.sv]
/*
  shared constants and carriers for the serial converter control block.
  assumes a 250 MHz system clock and pins sampled by that clock.
*/
package adc_serial_pkg;
  localparam int WIDE_BITS    = 14;     // result bits, wide variant
  localparam int NARROW_BITS  = 12;     // result bits, narrow variant
  localparam int SAMPLE_BITS  = 16;     // raw signed difference from front end
  localparam int CONVERT_START_STROBE_EDGES   = 16;     // serial edges that end a conversion
  localparam int NAP_PULSES   = 2;      // strobe pulses that pick nap
  localparam int SLEEP_PULSES = 4;      // strobe pulses that pick sleep
  localparam int BUF_DEPTH    = 2;      // result buffer entries
  localparam int SYS_PERIOD_PS = 4000;  // system clock period in ps
  localparam int SETUP_NS     = 3;      // strobe to serial edge setup time
  // least time, so round up, never below one cycle
  localparam int SETUP_CYC_RAW =
    (SETUP_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  localparam int SETUP_CYC = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
  localparam logic [2:0] PULSE_ZERO = 3'h0;  // power-down counter reset

  // both pins from the host, sampled together
  typedef struct packed {
    logic sck;   // serial clock pin level
    logic convert_start_strobe;  // convert_start_strobe pin level
  } pin_pair_t;

  // one finished conversion as it sits in the buffer
  typedef struct packed {
    logic                 clipped;  // input was outside full scale
    logic [WIDE_BITS-1:0] code;     // right-justified two's complement code
  } result_t;

  typedef enum logic [1:0] {
    CV_IDLE,  // acquiring or waiting for a strobe
    CV_RUN,   // counting serial edges of a conversion
    CV_PUSH   // finished word waits for buffer room
  } convert_start_strobe_state_t;
endpackage

// [rtl/adc_serial_ctrl.sv]
/*
  digital side of a serial sampling converter: strobe capture, conversion
  sequencing, two-entry result buffer, three-state serial output and the
  nap/sleep power-down decode.
  assumes the host drives the serial clock and strobe asynchronously to
  sys_clk_in, slowly enough that every pin edge is seen by the 4 ns clock,
  and that the front end hands a signed difference on diff_code_in.
*/
// Function
// - strobe rise captures input and starts conversion
// - each serial clock rise advances; rises in the setup window do not shift
// - acquisition runs from 16th edge to strobe
// - output word is previous conversion's result
// - result is two's complement
// - result is 14 or 12 bits wide
// - late strobe delays data one clock
// - two strobes with clock still gives nap
// - four or more strobes gives sleep
// - serial clock pulses wake from sleep
// - output three-state outside the result word
// - out of range input saturates the code
`timescale 1ns/100ps
module adc_serial_ctrl #(
  parameter int RES_BITS = adc_serial_pkg::WIDE_BITS  // 14 or 12
) (
  input  wire logic                     sys_clk_in,   // 250 MHz clock
  input  wire logic                     nrst_in,      // async reset, low
  input  wire logic                     ce_in,        // freezes all state
  input  wire adc_serial_pkg::pin_pair_t pins_in,     // host pins, async
  input  wire logic signed [adc_serial_pkg::SAMPLE_BITS-1:0]
                                        diff_code_in, // front end difference
  output logic                          result_serial_out, // serial data
  output logic                          result_oe_out,     // drive enable
  output logic                          hold_out,     // one-cycle hold pulse
  output logic                          acquire_out,  // acquisition window
  output logic                          nap_out,      // nap power-down
  output logic                          sleep_out     // sleep power-down
);
  import adc_serial_pkg::*;

  if (RES_BITS != WIDE_BITS && RES_BITS != NARROW_BITS) begin : g_bad_width
    $error("RES_BITS must be 12 or 14");
  end

  localparam logic [4:0] EDGE_LAST = 5'(CONVERT_START_STROBE_EDGES - 1);
  localparam logic [4:0] BITS_LAST = 5'(RES_BITS - 1);
  localparam logic [1:0] SETUP_LD  = 2'(SETUP_CYC);
  localparam logic [1:0] BUF_FULL  = 2'(BUF_DEPTH);

  // clamp the raw difference into the signed result range
  function automatic result_t saturate(input logic signed [SAMPLE_BITS-1:0] v);
    logic signed [SAMPLE_BITS-1:0] hi;
    logic signed [SAMPLE_BITS-1:0] lo;
    result_t                       r;
    hi = SAMPLE_BITS'((1 << (RES_BITS - 1)) - 1);
    lo = -hi - SAMPLE_BITS'(1);
    r  = '0;
    if (v > hi) begin
      r.code    = WIDE_BITS'(hi);  // zero then all ones
      r.clipped = 1'b1;
    end else if (v < lo) begin
      r.code    = WIDE_BITS'(lo);  // one then all zeros
      r.clipped = 1'b1;
    end else begin
      r.code = WIDE_BITS'(v);
    end
    r.code = r.code & WIDE_BITS'((1 << RES_BITS) - 1);
    return r;
  endfunction

  // pin synchroniser: stage one feeds stage two only
  pin_pair_t sync1_q, sync2_q, last_q;  // two flops plus edge history
  logic      convert_start_strobe_rise;                 // strobe rose this cycle
  logic      sck_rise;                  // serial clock rose this cycle
  logic      sck_edge;                  // serial clock moved either way

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_q <= '0;
      sync2_q <= '0;
      last_q  <= '0;
    end else if (ce_in) begin
      sync1_q <= pins_in;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
    end
  end

  always_comb begin
    convert_start_strobe_rise = ce_in & sync2_q.convert_start_strobe & ~last_q.convert_start_strobe;
    sck_rise  = ce_in & sync2_q.sck & ~last_q.sck;
    sck_edge  = ce_in & (sync2_q.sck ^ last_q.sck);
  end

  // main state: conversion, buffer, shifter, power-down
  convert_start_strobe_state_t             st_q, st_d;          // conversion sequencer
  logic [4:0]              edge_q, edge_d;      // serial edges this conversion
  result_t                 held_q, held_d;      // word captured at the strobe
  result_t                 mem_q [BUF_DEPTH];   // result buffer storage
  result_t                 mem_d [BUF_DEPTH];
  logic                    wp_q, wp_d, rp_q, rp_d;  // buffer pointers
  logic [1:0]              cnt_q, cnt_d;        // buffer fill level
  logic [WIDE_BITS-1:0]    sh_q, sh_d;          // output shift register
  logic [4:0]              left_q, left_d;      // bits still to present
  logic [1:0]              setup_q, setup_d;    // late-strobe window
  logic [2:0]              pulse_q, pulse_d;    // strobes with clock still
  logic                    sdo_q, sdo_d, oe_q, oe_d;
  logic                    hold_q, hold_d, acq_q, acq_d;
  logic                    nap_q, nap_d, slp_q, slp_d;
  logic                    push_valid, push_ready, pop_valid, pop_ready;
  logic                    late_edge;           // serial rise inside setup
  result_t                 head;                // word leaving the buffer

  always_comb begin
    st_d    = st_q;
    edge_d  = edge_q;
    held_d  = held_q;
    mem_d   = mem_q;
    wp_d    = wp_q;
    rp_d    = rp_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    left_d  = left_q;
    setup_d = setup_q;
    pulse_d = pulse_q;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    hold_d  = 1'b0;
    acq_d   = acq_q;
    nap_d   = nap_q;
    slp_d   = slp_q;
    head    = mem_q[rp_q];
    // buffer handshakes: full stalls the sequencer in CV_PUSH
    push_valid = (st_q == CV_PUSH);
    // a strobe pops in the same cycle, so a full buffer still has room
    push_ready = (cnt_q != BUF_FULL) || convert_start_strobe_rise;
    pop_valid  = (cnt_q != 2'h0);
    pop_ready  = convert_start_strobe_rise;
    // a rise inside the setup window is not used for data
    late_edge  = sck_rise & (convert_start_strobe_rise | (setup_q != 2'h0));
    if (setup_q != 2'h0 && ce_in) begin
      setup_d = setup_q - 2'h1;
    end

    // conversion sequencer
    case (st_q)
      CV_IDLE: begin
      end
      CV_RUN: begin
        if (sck_rise) begin
          edge_d = edge_q + 5'h1;
          if (edge_q == EDGE_LAST) begin
            st_d  = CV_PUSH;
            acq_d = 1'b1;
          end
        end
      end
      CV_PUSH: begin
        if (push_ready) begin
          st_d = CV_IDLE;
        end
      end
      default: st_d = CV_IDLE;
    endcase
    if (push_valid && push_ready) begin
      mem_d[wp_q] = held_q;
      wp_d        = ~wp_q;
    end
    if (pop_valid && pop_ready) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + 2'(push_valid & push_ready) - 2'(pop_valid & pop_ready);

    // strobe: hold input, start conversion, unload previous word
    if (convert_start_strobe_rise) begin
      held_d  = saturate(diff_code_in);
      hold_d  = 1'b1;
      acq_d   = 1'b0;
      st_d    = CV_RUN;
      // a rise that lands with the strobe is late for data only
      edge_d  = {4'h0, sck_rise};
      setup_d = SETUP_LD;
      // previous conversion goes out now; empty buffer sends zero
      sh_d    = pop_valid ? head.code : '0;
      sdo_d   = sh_d[RES_BITS-1];
      sh_d    = sh_d << 1;
      left_d  = BITS_LAST;
      oe_d    = 1'b1;
    end else if (sck_rise && !late_edge && oe_q) begin
      if (left_q != 5'h0) begin
        sdo_d  = sh_q[RES_BITS-1];
        sh_d   = sh_q << 1;
        left_d = left_q - 5'h1;
      end else begin
        oe_d  = 1'b0;
        sdo_d = 1'b0;
      end
    end

    // power-down decode: strobes counted while the clock stands
    if (sck_edge) begin
      pulse_d = PULSE_ZERO;
    end else if (convert_start_strobe_rise && pulse_q != 3'(SLEEP_PULSES)) begin
      pulse_d = pulse_q + 3'h1;
    end
    if (sck_rise) begin
      nap_d = 1'b0;
      slp_d = 1'b0;
    end else if (pulse_d == 3'(SLEEP_PULSES)) begin
      slp_d = 1'b1;
      nap_d = 1'b0;
    end else if (pulse_d == 3'(NAP_PULSES)) begin
      nap_d = 1'b1;
    end
  end

  // registers only; the gate on ce_in keeps everything frozen
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q    <= CV_IDLE;
      edge_q  <= 5'h0;
      held_q  <= '0;
      mem_q   <= '{default: '0};
      wp_q    <= 1'b0;
      rp_q    <= 1'b0;
      cnt_q   <= 2'h0;
      sh_q    <= '0;
      left_q  <= 5'h0;
      setup_q <= 2'h0;
      pulse_q <= PULSE_ZERO;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      hold_q  <= 1'b0;
      acq_q   <= 1'b0;
      nap_q   <= 1'b0;
      slp_q   <= 1'b0;
    end else if (ce_in) begin
      st_q    <= st_d;
      edge_q  <= edge_d;
      held_q  <= held_d;
      mem_q   <= mem_d;
      wp_q    <= wp_d;
      rp_q    <= rp_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      left_q  <= left_d;
      setup_q <= setup_d;
      pulse_q <= pulse_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      hold_q  <= hold_d;
      acq_q   <= acq_d;
      nap_q   <= nap_d;
      slp_q   <= slp_d;
    end
  end

  // outputs straight from flops
  always_comb begin
    result_serial_out = sdo_q;
    result_oe_out     = oe_q;
    hold_out          = hold_q;
    acquire_out       = acq_q;
    nap_out           = nap_q;
    sleep_out         = slp_q;
  end

  // checks beside the logic they guard
  a_hold_on_rise: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    convert_start_strobe_rise |=> hold_q && st_q == CV_RUN &&
      edge_q == {4'h0, $past(sck_rise)})
    else $error("strobe rise did not hold and start");
  a_edge_advance: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (st_q == CV_RUN && sck_rise && !convert_start_strobe_rise && edge_q != EDGE_LAST)
      |=> edge_q == $past(edge_q) + 5'h1)
    else $error("serial rise did not advance conversion");
  a_acq_window: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (st_q == CV_RUN && sck_rise && edge_q == EDGE_LAST && !convert_start_strobe_rise)
      |=> acq_q && st_q == CV_PUSH)
    else $error("acquisition did not open at 16th edge");
  a_acq_close: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    convert_start_strobe_rise |=> !acq_q)
    else $error("acquisition still open after strobe");
  a_out_lead: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (convert_start_strobe_rise && pop_valid)
      |=> oe_q && sdo_q == $past(head.code[RES_BITS-1]))
    else $error("first bit is not buffered result");
  a_late_hold: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (late_edge && !convert_start_strobe_rise) |=> $stable(sh_q) && $stable(left_q))
    else $error("late edge moved the data");
  a_oe_release: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (oe_q && sck_rise && !late_edge && !convert_start_strobe_rise && left_q == 5'h0)
      |=> !oe_q)
    else $error("output not released after last bit");
  a_nap_entry: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (convert_start_strobe_rise && !sck_edge && pulse_q == 3'h1) |=> nap_q)
    else $error("second still-clock strobe did not nap");
  a_sleep_entry: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (convert_start_strobe_rise && !sck_edge && pulse_q == 3'h3) |=> slp_q && !nap_q)
    else $error("fourth still-clock strobe did not sleep");
  a_wake_sck: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (slp_q && sck_rise) |=> !slp_q)
    else $error("serial clock did not wake from sleep");
  a_sat_clip: assert property (
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (convert_start_strobe_rise && diff_code_in > SAMPLE_BITS'((1 << (RES_BITS - 1)) - 1))
      |=> held_q.clipped && held_q.code[RES_BITS-1] == 1'b0)
    else $error("positive overrange not clamped");
endmodule

// [sim/adc_host.sv]
/*
  behavioural host for the serial converter: drives the serial clock and
  convert_start_strobe pins, latches result bits of both variants.
  assumes the bench calls its tasks just after a system clock edge.
*/
`timescale 1ns/100ps
module adc_host (
  output adc_serial_pkg::pin_pair_t pins_out, // serial clock and strobe
  input  wire logic                 sdo_w_in, // wide variant data
  input  wire logic                 oe_w_in,  // wide variant drive enable
  input  wire logic                 sdo_n_in, // narrow variant data
  input  wire logic                 oe_n_in   // narrow variant drive enable
);
  import adc_serial_pkg::*;
  logic line_w; // wide data wire as the host sees it
  logic line_n; // narrow data wire as the host sees it

  // a released line has no pull, so show the opposite of a zero drive
  assign line_w = oe_w_in ? sdo_w_in : ~sdo_w_in;
  assign line_n = oe_n_in ? sdo_n_in : ~sdo_n_in;

  // clock and strobe idle low, the link clock stands still between frames
  initial begin
    pins_out = '0;
  end

  // one strobe and 16 clock periods of 32 ns; a late strobe comes gap ns
  // before the first rise (0 puts both edges together)
  task automatic frame(input bit late, input int gap,
                       output logic [13:0] w, output logic [13:0] n,
                       output logic oe1, output logic oe16);
    int i;
    int s;
    w = '0;
    n = '0;
    s = late ? 2 : 1; // a late strobe delays the word one clock
    pins_out.convert_start_strobe = 1'b1;
    if (!late) begin // one full period of setup before the first rise
      #16 pins_out.convert_start_strobe = 1'b0;
      #16;
    end else begin // inside the setup window
      #(gap);
    end
    for (i = 1; i <= 16; i++) begin
      pins_out.sck = 1'b1;
      if (i >= s && i < s + 14) w = {w[12:0], line_w};
      if (i >= s && i < s + 12) n = {n[12:0], line_n};
      if (i == s) oe1 = oe_w_in & oe_n_in;
      if (i == 16) oe16 = oe_w_in | oe_n_in;
      #16 pins_out.sck = 1'b0;
      if (late && i == 1) pins_out.convert_start_strobe = 1'b0;
      #16;
    end
    #32; // acquisition time before the next strobe may come
  endtask

  // strobe pulses with the clock held low, spaced for the rate limit
  task automatic strobe_only(input int cnt);
    repeat (cnt) begin
      pins_out.convert_start_strobe = 1'b1;
      #16 pins_out.convert_start_strobe = 1'b0;
      #272;
    end
  endtask

  // a single clock pulse, used to wake the converter
  task automatic sck_pulse();
    pins_out.sck = 1'b1;
    #16 pins_out.sck = 1'b0;
    #16;
  endtask
endmodule

// [sim/adc_serial_ctrl_tb.sv]
/*
  self-checking bench for the serial converter control block: one wide and
  one narrow instance share the host pins and the front end difference.
  assumes the host model in adc_host.sv and the package constants.
*/
`timescale 1ns/100ps
module adc_serial_ctrl_tb;
  import adc_serial_pkg::*;
  logic                          sys_clk_in; // 250 MHz clock
  logic                          nrst_in;    // async reset, low
  pin_pair_t                     pins;       // host pins
  logic signed [SAMPLE_BITS-1:0] diff;       // front end difference
  logic                          sdo_w, oe_w, hold_w, acq_w, nap_w, sleep_w;
  logic                          sdo_n, oe_n; // narrow variant data pin
  logic [13:0]                   w, n;       // words latched by the host
  logic                          oe1, oe16;  // enable at first data rise and 16th rise
  int                            n_mismatch = 0;
  int                            n_checks = 0;
  int                            n_hold = 0; // cycles with hold high
  int                            prev;       // value held by last strobe

  adc_serial_ctrl #(.RES_BITS(WIDE_BITS)) uut (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .pins_in(pins), .diff_code_in(diff), .result_serial_out(sdo_w),
    .result_oe_out(oe_w), .hold_out(hold_w), .acquire_out(acq_w),
    .nap_out(nap_w), .sleep_out(sleep_w));
  adc_serial_ctrl #(.RES_BITS(NARROW_BITS)) uut_narrow (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .pins_in(pins), .diff_code_in(diff), .result_serial_out(sdo_n),
    .result_oe_out(oe_n), .hold_out(), .acquire_out(), .nap_out(),
    .sleep_out());
  adc_host host (
    .pins_out(pins), .sdo_w_in(sdo_w), .oe_w_in(oe_w),
    .sdo_n_in(sdo_n), .oe_n_in(oe_n));

  // a hold stuck high shows up as too many counted cycles
  always @(posedge sys_clk_in) begin
    if (hold_w === 1'b1) n_hold++;
  end

  // expected code: clip to full scale of b bits, keep b bits
  function automatic logic [13:0] sat(input int v, input int b);
    int lim;
    lim = (1 << (b - 1)) - 1;
    if (v > lim) v = lim;
    if (v < -lim - 1) v = -lim - 1;
    return v[13:0] & ((14'h1 << b) - 14'h1);
  endfunction

  task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // in range, negative and clipped values, each read one frame later
  task automatic t_stream();
    int vals[6];
    int k;
    vals = '{100, -100, 3000, -3000, 9000, -9000};
    prev = 0; // the buffer is empty at the first strobe
    for (k = 0; k < 6; k++) begin
      @(posedge sys_clk_in);
      #1 diff = SAMPLE_BITS'(vals[k]);
      host.frame(1'b0, 0, w, n, oe1, oe16);
      chk("wide word", sat(prev, WIDE_BITS), w);
      chk("narrow word", sat(prev, NARROW_BITS), n);
      chk("oe first", 14'h1, {13'h0, oe1});
      chk("oe after word", 14'h0, {13'h0, oe16});
      chk("acquire", 14'h1, {13'h0, acq_w});
      prev = vals[k];
    end
    chk("hold cycles", 14'h6, n_hold[13:0]);
  endtask

  // strobe with the first rise, then one cycle before it: the word slips
  // one clock, but that rise still counts for the conversion
  task automatic t_late();
    @(posedge sys_clk_in);
    #1 diff = 16'sh0007;
    host.frame(1'b1, 0, w, n, oe1, oe16);
    chk("late wide", sat(prev, WIDE_BITS), w);
    chk("late narrow", sat(prev, NARROW_BITS), n);
    chk("late oe", 14'h0, {13'h0, oe16});
    diff = -16'sh0005;
    host.frame(1'b1, 4, w, n, oe1, oe16);
    chk("after late", 14'h7, w);
    chk("gap narrow", 14'h7, n);
    chk("gap oe first", 14'h1, {13'h0, oe1});
    chk("gap oe", 14'h0, {13'h0, oe16});
    host.frame(1'b0, 0, w, n, oe1, oe16);
    chk("after gap", sat(-5, WIDE_BITS), w);
    chk("after gap narrow", sat(-5, NARROW_BITS), n);
  endtask

  // two strobes give nap, four give sleep, a clock pulse wakes
  // the reference settles far later than this run lasts, so no word is
  // read after the wake
  task automatic t_power();
    host.strobe_only(2);
    repeat (4) @(posedge sys_clk_in);
    #1;
    chk("nap", 14'h1, {13'h0, nap_w});
    chk("no sleep", 14'h0, {13'h0, sleep_w});
    host.strobe_only(2);
    repeat (4) @(posedge sys_clk_in);
    #1;
    chk("sleep", 14'h1, {13'h0, sleep_w});
    chk("nap off", 14'h0, {13'h0, nap_w});
    host.sck_pulse();
    repeat (4) @(posedge sys_clk_in);
    #1;
    chk("wake", 14'h0, {13'h0, sleep_w});
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  // the whole run takes about 6.5 us, so 50 us means a hang
  initial begin
    #50000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    nrst_in = 1'b0;
    diff = '0;
    repeat (10) @(posedge sys_clk_in);
    #1 nrst_in = 1'b1;
    repeat (5) @(posedge sys_clk_in);
    t_stream();
    t_late();
    t_power();
    end_of_test();
  end
endmodule
